/* File: uart_irq_ctl.sv */
// Purpose: interrupt priority, fifo control and line format registers
// Assumes: fifo, shifter and baud logic sit outside and feed status in
// Notes: ref_clk doubles as the crystal clock; one always_comb, two always_ff
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "uart_irq_cfg.svh"

module uart_irq_ctl #(
  parameter int FIFO_DEPTH = 64,
  parameter int TMO_MAX = 1048575
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // status from the receive and transmit paths, same clock
  input wire logic [6:0] rx_level,
  input wire logic [6:0] tx_level,
  input wire logic rx_push,
  input wire logic line_err,
  input wire logic thr_empty,
  input wire logic rs485_tx_done,
  input wire logic modem_delta,
  input wire logic gpin_toggle,
  input wire logic xoff_match,
  input wire logic xon_match,
  input wire logic special_match,
  input wire logic [19:0] bit_clks,
  // pins from outside the clock domain
  input wire logic rts_pin,
  input wire logic cts_pin,
  // side-read and holding register write pulses from other registers
  input wire logic msr_read,
  input wire logic ios_read,
  input wire logic rhr_read,
  input wire logic thr_write,
  // outputs
  output logic irq_n,
  output logic [7:0] source_code,
  output logic fifo_en,
  output logic rx_fifo_rst,
  output logic tx_fifo_rst,
  output uart_irq_pkg::fmt_t char_fmt,
  output logic [6:0] rx_trigger,
  output logic [6:0] tx_trigger
);

  // ========================================================================
  // helpers

  // rx trigger from fifo_control bits 7:6
  function automatic logic [6:0] rx_trig(input logic [1:0] s);
    case (s)
      2'b00: rx_trig = 7'd8;
      2'b01: rx_trig = 7'd16;
      2'b10: rx_trig = 7'd56;
      default: rx_trig = 7'd60;
    endcase
  endfunction

  // tx trigger from fifo_control bits 5:4
  function automatic logic [6:0] tx_trig(input logic [1:0] s);
    case (s)
      2'b00: tx_trig = 7'd8;
      2'b01: tx_trig = 7'd16;
      2'b10: tx_trig = 7'd32;
      default: tx_trig = 7'd56;
    endcase
  endfunction

  // priority encoder of pending sources into the status code
  function automatic logic [5:0] encode(input uart_irq_pkg::pend_t p);
    if (p.line) encode = `CODE_LINE;
    else if (p.timeout) encode = `CODE_TIMEOUT;
    else if (p.receive_ready_irq) encode = `CODE_RECEIVE_READY_IRQ;
    else if (p.transmit_ready_irq) encode = `CODE_TRANSMIT_READY_IRQ;
    else if (p.modem) encode = `CODE_MODEM;
    else if (p.gpin) encode = `CODE_GPIN;
    else if (p.xoff) encode = `CODE_XOFF;
    else if (p.flow) encode = `CODE_FLOW;
    else encode = `CODE_NONE;
  endfunction

  // refuse sizes that the trigger tables and the counter cannot serve
  if (FIFO_DEPTH != 64 || TMO_MAX < 1 || TMO_MAX > 1048575)
  begin : g_bad_params
    $error("uart_irq_ctl: unsupported parameter values");
  end

  uart_irq_pkg::state_t q, d;
  uart_irq_pkg::pend_t live; // sources gated by mask, except gpin
  logic gate; // enhanced functions allowed
  logic [6:0] rtrig, ttrig;
  logic [19:0] tmo_limit;
  logic [6:0] spaces;
  logic [3:0] wl;
  logic [31:0] rd_word;

  // ========================================================================
  // combinational next state
  always_comb
  begin
    d = q;
    gate = q.enhanced_feature_ctl[`EF_GATE];
    rtrig = rx_trig(q.fctl[7:6]);
    ttrig = gate ? tx_trig(q.fctl[5:4]) : 7'd8;
    wl = 4'd5 + {2'b00, q.lfmt[1:0]};
    spaces = 7'(FIFO_DEPTH) - tx_level;
    // 4 chars of (start+data+parity+stop) plus 12 bits
    tmo_limit = 20'(bit_clks * (4 * (1 + wl + q.lfmt[3] + 1 + q.lfmt[2])
                + 12));
    // pin synchronisers
    d.rts_s = {q.rts_s[0], rts_pin};
    d.cts_s = {q.cts_s[0], cts_pin};
    d.rts_d = q.rts_s[1];
    d.cts_d = q.cts_s[1];
    // one-cycle side-effect pulses
    d.isr_rd = 1'b0;
    d.thr_wr = thr_write;
    d.msr_rd = msr_read;
    d.ios_rd = ios_read;
    d.rhr_rd = rhr_read;
    // level sources, evaluated each cycle
    live = '0;
    live.line = q.mask[2] & line_err;
    live.receive_ready_irq = q.mask[0] & (q.fctl[`FC_ENABLE] ? (rx_level >= rtrig)
                 : (rx_level != 7'd0));
    // timeout counter, reset by push or pop or empty fifo
    if (rx_push || rhr_read || rx_level == 7'd0)
      d.tmo_cnt = '0;
    else if (q.tmo_cnt != 20'hF_FFFF)
      d.tmo_cnt = q.tmo_cnt + 20'd1;
    // sticky sources: set wins over clear
    if (rhr_read) d.sticky.timeout = 1'b0;
    if (q.fctl[`FC_ENABLE] && q.mask[0] && q.tmo_cnt >= tmo_limit
        && rx_level != 7'd0)
      d.sticky.timeout = 1'b1;
    if (q.isr_rd && q.cur_code == `CODE_TRANSMIT_READY_IRQ) d.sticky.transmit_ready_irq = 1'b0;
    if (thr_write) d.sticky.transmit_ready_irq = 1'b0;
    d.transmit_ready_irq_arm = q.fctl[`FC_ENABLE] ? (spaces > ttrig) : thr_empty;
    if ((d.transmit_ready_irq_arm && !q.transmit_ready_irq_arm) || rs485_tx_done)
      d.sticky.transmit_ready_irq = 1'b1;
    if (msr_read)
    begin
      d.sticky.modem = 1'b0;
      d.sticky.flow = 1'b0;
    end
    if (modem_delta) d.sticky.modem = 1'b1;
    if (ios_read) d.sticky.gpin = 1'b0;
    if (gpin_toggle) d.sticky.gpin = 1'b1;
    if (xon_match) d.sticky.xoff = 1'b0;
    // special char clears on a source read, xoff only on xon
    if (q.isr_rd && q.cur_code == `CODE_XOFF) d.spec_pend = 1'b0;
    if (gate && q.mask[5] && xoff_match) d.sticky.xoff = 1'b1;
    if (gate && q.mask[5] && special_match) d.spec_pend = 1'b1;
    if (gate && ((q.mask[6] && q.rts_s[1] && !q.rts_d) ||
                 (q.mask[7] && q.cts_s[1] && !q.cts_d)))
      d.sticky.flow = 1'b1;
    live.timeout = q.sticky.timeout;
    live.transmit_ready_irq = q.mask[1] & q.sticky.transmit_ready_irq;
    live.modem = q.mask[3] & q.sticky.modem;
    live.gpin = q.sticky.gpin;
    live.xoff = gate & (q.sticky.xoff | q.spec_pend);
    live.flow = gate & q.sticky.flow;
    // only the top pending code shows; lower ones wait
    d.cur_code = encode(live);
    // fifo reset pulses last three crystal clocks
    if (q.rst_cnt != 2'd0)
      d.rst_cnt = q.rst_cnt - 2'd1;
    else
    begin
      d.rx_rst = 1'b0;
      d.tx_rst = 1'b0;
    end
    // ---------------------- bus write path
    if (!q.awv && s_axi_awvalid)
    begin
      d.awv = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (!q.wv && s_axi_wvalid)
    begin
      d.wv = 1'b1;
      d.wdata = s_axi_wdata;
      d.wen = s_axi_wstrb[0];
    end
    case (q.ws)
      uart_irq_pkg::WR_IDLE:
      begin
        if (q.awv && q.wv)
        begin
          d.ws = uart_irq_pkg::WR_RESP;
          d.bvalid = 1'b1;
          d.bresp = 2'b00;
          d.awv = 1'b0;
          d.wv = 1'b0;
          if (q.wen)
          begin
            case (q.awaddr)
              `OFS_INTERRUPT_MASK:
                d.mask = gate ? q.wdata[7:0]
                         : {q.mask[7:4], q.wdata[3:0]};
              `OFS_FIFO_CONTROL:
              begin
                if (!q.wdata[`FC_ENABLE])
                  d.fctl = {q.fctl[7:1], 1'b0};
                else
                begin
                  d.fctl = {q.wdata[7:6], gate ? q.wdata[5:4]
                            : q.fctl[5:4], 4'b0001};
                  if (q.wdata[`FC_RX_RST] || q.wdata[`FC_TX_RST])
                    d.rst_cnt = 2'(`FIFO_RST_CLKS - 1);
                  d.rx_rst = q.wdata[`FC_RX_RST];
                  d.tx_rst = q.wdata[`FC_TX_RST];
                end
              end
              `OFS_LINE_FORMAT: d.lfmt = q.wdata[7:0];
              `OFS_ENHANCED_CTL: d.enhanced_feature_ctl = q.wdata[7:0];
              `OFS_INTERRUPT_SOURCE, `OFS_EVENT_INPUTS,
              `OFS_FIFO_STATUS, `OFS_SIDE_READS: d.bresp = 2'b00;
              default: d.bresp = 2'b10;
            endcase
          end
        end
      end
      uart_irq_pkg::WR_RESP:
        if (s_axi_bready)
        begin
          d.bvalid = 1'b0;
          d.ws = uart_irq_pkg::WR_IDLE;
        end
      default: d.ws = uart_irq_pkg::WR_IDLE;
    endcase
    // ---------------------- bus read path
    rd_word = '0;
    case (s_axi_araddr)
      `OFS_INTERRUPT_MASK: rd_word[7:0] = q.mask;
      `OFS_INTERRUPT_SOURCE:
        rd_word[7:0] = {{2{q.fctl[`FC_ENABLE]}}, q.cur_code};
      `OFS_LINE_FORMAT: rd_word[7:0] = q.lfmt;
      `OFS_ENHANCED_CTL: rd_word[7:0] = q.enhanced_feature_ctl;
      `OFS_FIFO_STATUS: rd_word[13:0] = {ttrig, rtrig};
      `OFS_FIFO_CONTROL, `OFS_EVENT_INPUTS, `OFS_SIDE_READS:
        rd_word = '0;
      default: rd_word = 32'hDEAD_BEEF;
    endcase
    if (q.rvalid)
    begin
      if (s_axi_rready) d.rvalid = 1'b0;
    end
    else if (s_axi_arvalid)
    begin
      d.rvalid = 1'b1;
      d.rdata = (rd_word == 32'hDEAD_BEEF) ? '0 : rd_word;
      d.rresp = (rd_word == 32'hDEAD_BEEF) ? 2'b10 : 2'b00;
      d.isr_rd = (s_axi_araddr == `OFS_INTERRUPT_SOURCE);
    end
  end

  // ========================================================================
  // state register, synchronous reset
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.mask <= `RST_INTERRUPT_MASK;
      q.lfmt <= `RST_LINE_FORMAT;
      q.fctl <= `RST_FIFO_CONTROL;
      q.cur_code <= `CODE_NONE;
      q.ws <= uart_irq_pkg::WR_IDLE;
    end
    else
      q <= d;
  end

  // ========================================================================
  // registered outputs
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      irq_n <= 1'b1;
      source_code <= {2'b00, `CODE_NONE};
      fifo_en <= 1'b0;
      rx_fifo_rst <= 1'b0;
      tx_fifo_rst <= 1'b0;
      char_fmt <= '{data_bits: 4'd6, stop_half_bits: 2'd0, parity_en: 1'b1,
        parity_forced: 1'b0, parity_value: 1'b0, parity_even: 1'b1};
      rx_trigger <= 7'd8;
      tx_trigger <= 7'd8;
    end
    else
    begin
      irq_n <= (d.cur_code == `CODE_NONE);
      source_code <= {{2{d.fctl[`FC_ENABLE]}}, d.cur_code};
      fifo_en <= d.fctl[`FC_ENABLE];
      rx_fifo_rst <= d.rx_rst;
      tx_fifo_rst <= d.tx_rst;
      char_fmt.data_bits <= 4'd5 + {2'b00, d.lfmt[1:0]};
      // stop length in half bits: 2 or 3; the two-stop case gives 0
      char_fmt.stop_half_bits <= !d.lfmt[2] ? 2'd2 :
        (d.lfmt[1:0] == 2'b00 ? 2'd3 : 2'd0);
      char_fmt.parity_en <= d.lfmt[3];
      char_fmt.parity_even <= d.lfmt[4];
      char_fmt.parity_forced <= d.lfmt[5];
      char_fmt.parity_value <= !d.lfmt[4];
      rx_trigger <= rx_trig(d.fctl[7:6]);
      tx_trigger <= d.enhanced_feature_ctl[`EF_GATE] ? tx_trig(d.fctl[5:4]) : 7'd8;
    end
  end

  assign s_axi_awready = !q.awv;
  assign s_axi_wready = !q.wv;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  // ========================================================================
  // assertions
  a_idle_code_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (live == '0) |=> (q.cur_code == `CODE_NONE && irq_n))
    else $error("idle code bit 0 not set");
  a_line_top_prio: assert property (@(posedge ref_clk) disable iff (!rst_n)
    live.line |=> q.cur_code == `CODE_LINE)
    else $error("line status not given priority");
  a_fifo_rst_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(q.rx_rst) |-> q.rx_rst[*3])
    else $error("rx fifo reset shorter than three clocks");
  a_fctl_ignore: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (q.ws == uart_irq_pkg::WR_IDLE && q.awv && q.wv && q.wen &&
     q.awaddr == `OFS_FIFO_CONTROL && !q.wdata[0])
    |=> (!q.fctl[0] && $stable(q.fctl[7:1])))
    else $error("fifo control not cleared");
  a_mask_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!gate && $past(!q.enhanced_feature_ctl[4])) |-> $stable(q.mask[7:4]))
    else $error("enhanced mask bits changed ungated");
  a_tx_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (thr_write && !rs485_tx_done && !(d.transmit_ready_irq_arm && !q.transmit_ready_irq_arm))
    |=> !q.sticky.transmit_ready_irq)
    else $error("tx ready not cleared by write");
  a_xoff_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (q.sticky.xoff && !xon_match) |=> q.sticky.xoff)
    else $error("xoff flag dropped early");
  a_flow_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (gate && q.mask[7] && q.cts_s[1] && !q.cts_d) |=> q.sticky.flow)
    else $error("cts rise did not flag");
  c_line_irq: cover property (@(posedge ref_clk) q.cur_code == `CODE_LINE);
  c_timeout: cover property (@(posedge ref_clk) $rose(q.sticky.timeout));
  c_flow: cover property (@(posedge ref_clk) $rose(q.sticky.flow));

endmodule // uart_irq_ctl

/* File: uart_irq_cfg.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit axi4-lite register bus, 40 MHz ref_clk
// Notes: definitions only
`ifndef UART_IRQ_CFG_SVH
`define UART_IRQ_CFG_SVH
// ==========================================================================
// register byte offsets
`define OFS_INTERRUPT_MASK   12'h000
`define OFS_INTERRUPT_SOURCE 12'h004
`define OFS_FIFO_CONTROL     12'h008
`define OFS_LINE_FORMAT      12'h00C
`define OFS_ENHANCED_CTL     12'h010
`define OFS_EVENT_INPUTS     12'h014
`define OFS_FIFO_STATUS      12'h018
`define OFS_SIDE_READS       12'h01C
// ==========================================================================
// reset values
`define RST_INTERRUPT_MASK 8'h00
`define RST_LINE_FORMAT    8'h1D
`define RST_FIFO_CONTROL   8'h00
// ==========================================================================
// interrupt source codes, bits 5..0
`define CODE_LINE    6'h06
`define CODE_TIMEOUT 6'h0C
`define CODE_RECEIVE_READY_IRQ   6'h04
`define CODE_TRANSMIT_READY_IRQ   6'h02
`define CODE_MODEM   6'h00
`define CODE_GPIN    6'h30
`define CODE_XOFF    6'h10
`define CODE_FLOW    6'h20
`define CODE_NONE    6'h01
// ==========================================================================
// field positions
`define FC_ENABLE 0
`define FC_RX_RST 1
`define FC_TX_RST 2
`define EF_GATE   4
// ==========================================================================
// timing: fifo reset holds at least 3 crystal clocks
`define FIFO_RST_CLKS 3
`endif

/* File: uart_irq_pkg.sv */
// Purpose: types shared by the interrupt and line control block
// Assumes: constants live in uart_irq_cfg.svh
// Notes: state carrier is one packed struct
package uart_irq_pkg;
  // per-source pending flags, highest priority first
  typedef struct packed {
    logic line;
    logic timeout;
    logic receive_ready_irq;
    logic transmit_ready_irq;
    logic modem;
    logic gpin;
    logic xoff;
    logic flow;
  } pend_t;
  // character format derived from line_format
  typedef struct packed {
    logic [3:0] data_bits;
    logic [1:0] stop_half_bits;
    logic parity_en;
    logic parity_forced;
    logic parity_value;
    logic parity_even;
  } fmt_t;
  // bus write channel states
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_t;
  // all registered state of the block except the output registers
  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] fctl;
    logic [7:0] lfmt;
    logic [7:0] enhanced_feature_ctl;
    pend_t sticky;
    logic transmit_ready_irq_arm;
    logic spec_pend; // special character pending, cleared by a source read
    logic [5:0] cur_code;
    logic [1:0] rst_cnt;
    logic rx_rst;
    logic tx_rst;
    logic [19:0] tmo_cnt;
    logic [1:0] rts_s;
    logic [1:0] cts_s;
    logic rts_d;
    logic cts_d;
    logic awv;
    logic wv;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic wen; // byte lane 0 strobe, latched with the data
    wr_state_t ws;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] bresp;
    logic isr_rd;
    logic thr_wr;
    logic msr_rd;
    logic ios_rd;
    logic rhr_rd;
  } state_t;
endpackage

/* File: uart_host_model.sv */
// Purpose: register bus host that stands at the far side of the block
// Assumes: axi4-lite, one write and one read at a time, 32-bit data
// Notes: waits are open ended; the bench watchdog cuts a hang short
`timescale 1ns/1ps
// ==========================================================================
// host model
module uart_host_model (
  // clock
  input wire logic ref_clk,
  // write channels
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read channels
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // everything idle at time zero
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end
  // one write: address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      // response only counts once sampled with bready high
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  // one read: data taken at the edge where rvalid is seen
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
endmodule // uart_host_model

/* File: uart_interrupt_fifo_line_control_bench.sv */
// Purpose: self-checking bench for the interrupt and line control block
// Assumes: host model speaks the register bus, bench drives status inputs
// Notes: bit_clks kept small so the receive timeout stays short
`timescale 1ns/1ps
`include "uart_irq_cfg.svh"
// ==========================================================================
// bench top
module uart_interrupt_fifo_line_control_bench;
  // clock, reset and status inputs
  logic ref_clk;
  logic rst_n;
  logic [6:0] rx_level;
  logic [6:0] tx_level;
  logic line_err;
  logic thr_empty;
  logic rts_pin;
  logic cts_pin;
  logic [19:0] bit_clks;
  // event pulses: 0 push 1 rhr 2 thr 3 msr 4 ios 5 modem 6 gpin
  // 7 xoff 8 xon 9 special 10 rs485
  logic [10:0] ev;
  // bus wires
  logic [11:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  // design outputs
  logic irq_n;
  logic [7:0] source_code;
  logic fifo_en;
  logic rx_fifo_rst;
  logic tx_fifo_rst;
  uart_irq_pkg::fmt_t char_fmt;
  logic [6:0] rx_trigger;
  logic [6:0] tx_trigger;
  // bookkeeping
  int errors = 0;
  int n_compared = 0;
  int rx_run = 0;
  int tx_run = 0;
  int rxt[4] = '{8, 16, 56, 60};
  int txt[4] = '{8, 16, 32, 56};
  logic [31:0] d;
  logic [1:0] r;
  int n;
  // ========================================================================
  // instances
  uart_irq_ctl i_uart_irq_ctl (.ref_clk, .rst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_level,
    .tx_level, .rx_push(ev[0]), .line_err, .thr_empty,
    .rs485_tx_done(ev[10]), .modem_delta(ev[5]), .gpin_toggle(ev[6]),
    .xoff_match(ev[7]), .xon_match(ev[8]), .special_match(ev[9]),
    .bit_clks, .rts_pin, .cts_pin, .msr_read(ev[3]), .ios_read(ev[4]),
    .rhr_read(ev[1]), .thr_write(ev[2]), .irq_n, .source_code, .fifo_en,
    .rx_fifo_rst, .tx_fifo_rst, .char_fmt, .rx_trigger, .tx_trigger);
  uart_host_model i_uart_host_model (.ref_clk, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // ========================================================================
  // clock and fifo reset pulse length counters
  initial
  begin
    ref_clk = 1'b0;
    forever
      #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    rx_run <= rx_run + int'(rx_fifo_rst === 1'b1);
    tx_run <= tx_run + int'(tx_fifo_rst === 1'b1);
  end
  // ========================================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [1:0] rr;
    i_uart_host_model.wr(a, v, rr);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] dd;
    logic [1:0] rr;
    i_uart_host_model.rd(a, dd, rr);
    chk(dd, e);
  endtask
  // one-cycle event pulse, launched on an edge
  task automatic pulse(input int b);
    @(posedge ref_clk);
    ev[b] <= 1'b1;
    @(posedge ref_clk);
    ev <= '0;
  endtask
  // let registered outputs land before looking at them
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ========================================================================
  // watchdog: tests need about a thousand cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    tally_and_finish;
  end
  // ========================================================================
  // main sequence
  initial
  begin
    {rst_n, line_err, thr_empty, rts_pin, cts_pin, ev} = '0;
    rx_level = 7'h00;
    tx_level = 7'h40;
    bit_clks = 20'h0_0010;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset state and address map
    rd(`OFS_LINE_FORMAT, 32'h0000_001D);
    rd(`OFS_INTERRUPT_MASK, 32'h0000_0000);
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_0001);
    rd(`OFS_FIFO_CONTROL, 32'h0000_0000);
    rd(12'h014, 32'h0000_0000);
    i_uart_host_model.rd(12'h020, d, r);
    chk({d[29:0], r}, 32'h0000_0002);
    i_uart_host_model.wr(12'h020, 32'h0000_00FF, r);
    chk(32'(r), 32'h0000_0002);
    settle;
    chk(32'(char_fmt.data_bits), 32'h0000_0006);
    chk(32'({char_fmt.parity_en, char_fmt.parity_even}), 32'h3);
    chk(32'(char_fmt.stop_half_bits), 32'h0000_0000);
    chk(32'({rx_trigger, tx_trigger, fifo_en, irq_n}), 32'h1021);
    // word length, then parity kinds
    for (int k = 0; k < 4; k++)
    begin
      wr(`OFS_LINE_FORMAT, 32'(k));
      settle;
      chk(32'(char_fmt.data_bits), 32'(k + 5));
      chk(32'(char_fmt.parity_en), 32'h0000_0000);
      chk(32'(char_fmt.stop_half_bits), 32'h0000_0002);
    end
    // five-bit words with the long stop setting give one and a half
    wr(`OFS_LINE_FORMAT, 32'h0000_0004);
    settle;
    chk(32'(char_fmt.stop_half_bits), 32'h0000_0003);
    wr(`OFS_LINE_FORMAT, 32'h0000_0038);
    settle;
    chk(32'({char_fmt.parity_forced, char_fmt.parity_value}), 32'h2);
    wr(`OFS_LINE_FORMAT, 32'h0000_0028);
    settle;
    chk(32'({char_fmt.parity_forced, char_fmt.parity_value}), 32'h3);
    wr(`OFS_LINE_FORMAT, 32'h0000_0008);
    settle;
    chk(32'({char_fmt.parity_en, char_fmt.parity_even}), 32'h2);
    // fifo control: writes without the enable bit only clear the enable bit
    wr(`OFS_FIFO_CONTROL, 32'h0000_0006);
    settle;
    chk(32'({fifo_en, rx_run[3:0], tx_run[3:0]}), 32'h000);
    wr(`OFS_FIFO_CONTROL, 32'h0000_0003);
    settle;
    wr(`OFS_FIFO_CONTROL, 32'h0000_0005);
    settle;
    chk(32'(rx_run * 16 + tx_run), 32'h0000_0033);
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00C1);
    for (int k = 0; k < 4; k++)
    begin
      wr(`OFS_FIFO_CONTROL, 32'(k * 64 + 1));
      settle;
      chk(32'(rx_trigger), 32'(rxt[k]));
    end
    // enhanced bits locked until the gate opens
    wr(`OFS_INTERRUPT_MASK, 32'h0000_00E0);
    rd(`OFS_INTERRUPT_MASK, 32'h0000_0000);
    wr(`OFS_FIFO_CONTROL, 32'h0000_0031);
    settle;
    chk(32'(tx_trigger), 32'h0000_0008);
    wr(`OFS_ENHANCED_CTL, 32'h0000_0010);
    // locked write must not have reached the tx trigger field
    rd(`OFS_FIFO_STATUS, 32'h0000_0408);
    for (int k = 0; k < 4; k++)
    begin
      wr(`OFS_FIFO_CONTROL, 32'(k * 16 + 1));
      settle;
      chk(32'(tx_trigger), 32'(txt[k]));
    end
    // priority: line over data ready over modem
    wr(`OFS_INTERRUPT_MASK, 32'h0000_000D);
    line_err <= 1'b1;
    rx_level <= 7'h08;
    pulse(5);
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00C6);
    chk(32'({irq_n, source_code}), 32'h0000_00C6);
    line_err <= 1'b0;
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00C4);
    rx_level <= 7'h07;
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00C0);
    pulse(3);
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00C1);
    // receive timeout: 4 chars of 8 bits plus 12 bits, 16 clocks a bit
    rx_level <= 7'h01;
    pulse(0);
    n = 0;
    while (irq_n !== 1'b0 && n < 4000)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk(32'(n >= 704 && n < 712), 32'h0000_0001);
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00CC);
    rx_level <= 7'h00;
    pulse(1);
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00C1);
    // xoff stays until xon, special clears on a source read
    wr(`OFS_INTERRUPT_MASK, 32'h0000_00E0);
    pulse(7);
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00D0);
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00D0);
    pulse(8);
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00C1);
    pulse(9);
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00D0);
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00C1);
    // rising flow-control pins, cleared by a modem status read
    rts_pin <= 1'b1;
    settle;
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00E0);
    pulse(3);
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00C1);
    @(posedge ref_clk);
    cts_pin <= 1'b1;
    settle;
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00E0);
    pulse(3);
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00C1);
    // transmit ready from free spaces, cleared by the source read
    wr(`OFS_INTERRUPT_MASK, 32'h0000_0002);
    tx_level <= 7'h00;
    settle;
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00C2);
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00C1);
    // re-arm, then clear by a holding register write
    tx_level <= 7'h40;
    settle;
    tx_level <= 7'h00;
    settle;
    chk(32'(irq_n), 32'h0000_0000);
    pulse(2);
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00C1);
    // rs485 done, then a general-purpose input toggle
    pulse(10);
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00C2);
    pulse(6);
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00F0);
    pulse(4);
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_00C1);
    // fifo off again
    wr(`OFS_FIFO_CONTROL, 32'h0000_0000);
    rd(`OFS_INTERRUPT_SOURCE, 32'h0000_0001);
    tally_and_finish;
  end
endmodule // uart_interrupt_fifo_line_control_bench
